/* File: sbf_regs.vh */
// Register offsets, field positions, reset values and timing counts of the serial block.
`ifndef SBF_REGS_VH
`define SBF_REGS_VH
`define SBF_ADDR_W 2
`define SBF_OFS_BAUD 2'h0
`define SBF_OFS_CTRL 2'h1
`define SBF_OFS_STAT 2'h2
`define SBF_OFS_DATA 2'h3
`define SBF_BAUD_RATE_LSB 0
`define SBF_BAUD_PRE_LSB 4
`define SBF_CTRL_XMIT_ON 0
`define SBF_CTRL_RECV_ON 1
`define SBF_CTRL_TXE_IE 2
`define SBF_CTRL_TXC_IE 3
`define SBF_CTRL_RXF_IE 4
`define SBF_CTRL_IDLE_IE 5
`define SBF_CTRL_RESET 8'h00
`define SBF_ST_TXE 7
`define SBF_ST_TXC 6
`define SBF_ST_RXF 5
`define SBF_ST_IDLE 4
`define SBF_ST_OVR 3
`define SBF_ST_NOISE 2
`define SBF_ST_FRAME 1
`define SBF_SAMPLES_PER_BIT 16
`define SBF_BITS_PER_CHAR 10
`define SBF_IDLE_TICKS 160
`define SBF_PRE_DIV1 8'h01
`define SBF_PRE_DIV3 8'h03
`define SBF_PRE_DIV4 8'h04
`define SBF_PRE_DIV13 8'h0D
`define SBF_PRE_DIV39 8'h27
`endif

/* File: sbf_sync3.v */
// Three-stage synchroniser for a pin that arrives from outside the clock domain.
`timescale 1ns/100ps
module sbf_sync3 #(
	parameter RESET_VAL = 1'b1
) (
	// Clock and reset.
	input wire clk,
	input wire rst_n,
	// Pin and synchronised level.
	input wire pin_in,
	output reg level_q
);
	reg s1_q;
	reg s2_q;
	reg s3_q;

	// The level changes only once the second and third stages agree.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= RESET_VAL;
			s2_q <= RESET_VAL;
			s3_q <= RESET_VAL;
			level_q <= RESET_VAL;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				level_q <= s3_q;
			end
		end
	end
endmodule

/* File: sbf_baud_div.v */
// Prescaler and power-of-two rate divider producing the sample and bit enables.
`timescale 1ns/100ps
`include "sbf_regs.vh"
module sbf_baud_div (
	// Clock and reset.
	input wire clk,
	input wire rst_n,
	// Rate selection.
	input wire [2:0] prescaler_select,
	input wire [2:0] rate_divider_select,
	// One-cycle enables.
	output reg sample_tick_q,
	output reg bit_tick_q
);
	reg [7:0] pre_cnt_q;
	reg [6:0] rate_cnt_q;
	reg [3:0] smp_cnt_q;
	wire [7:0] pre_div;
	wire pre_tick;
	wire rate_tick;

	// Undecoded prescaler codes fall back to the divide-by-one setting.
	function [7:0] pre_decode;
		input [2:0] sel;
		begin
			case (sel)
				3'd1: pre_decode = `SBF_PRE_DIV3;
				3'd2: pre_decode = `SBF_PRE_DIV4;
				3'd3: pre_decode = `SBF_PRE_DIV13;
				3'd4: pre_decode = `SBF_PRE_DIV39;
				default: pre_decode = `SBF_PRE_DIV1;
			endcase
		end
	endfunction

	assign pre_div = pre_decode(prescaler_select);
	assign pre_tick = (pre_cnt_q >= pre_div - 8'h01);
	// Mask of the low counter bits gives divide by 1 to 128.
	assign rate_tick = pre_tick &
		((rate_cnt_q & ((7'h01 << rate_divider_select) - 7'h01)) ==
		((7'h01 << rate_divider_select) - 7'h01));

	// Both stages run in series; the sample enable is the sixteen-times clock.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_cnt_q <= 8'h00;
			rate_cnt_q <= 7'h00;
			smp_cnt_q <= 4'h0;
			sample_tick_q <= 1'b0;
			bit_tick_q <= 1'b0;
		end else begin
			pre_cnt_q <= pre_tick ? 8'h00 : pre_cnt_q + 8'h01; // see R20
			if (pre_tick) begin
				rate_cnt_q <= rate_cnt_q + 7'h01; // see R01
			end
			sample_tick_q <= rate_tick; // see R02
			if (rate_tick) begin
				smp_cnt_q <= smp_cnt_q + 4'h1;
			end
			bit_tick_q <= rate_tick && (smp_cnt_q == 4'hF); // see R03
		end
	end
endmodule

/* File: sbf_top.v */
// Serial transmitter and receiver with baud chain, status flags and register port.
`timescale 1ns/100ps
`include "sbf_regs.vh"
// Operation
// R01: Rate select divides the prescaler output by a power of two, 1 to 128.
// R02: Prescaler and rate divider in series give the sixteen-times sample clock.
// R03: Bit clock is the sample clock divided by sixteen.
// R04: Rate select survives reset and may be written any time.
// R05: Flags are set by hardware and held until software clears them.
// R06: Turning the transmitter on sets holding-empty and complete flags.
// R07: Holding-empty flag with its enable requests an interrupt.
// R08: Complete flag with its enable requests an interrupt.
// R09: Disabling the transmitter lets the current character finish.
// R10: Only reset stops the transmitter at once.
// R11: Disabling while idle returns the pin to general use at a bit tick.
// R12: Disabling during a transfer discards the waiting character.
// R13: The final character sets holding-empty and complete flags though disabled.
// R14: Receive-full is set when a character reaches the holding register.
// R15: On overrun the new character is dropped and overrun is set instead.
// R16: Noise and framing flags describe the held character and never interrupt.
// R17: Line high for one character time counts as idle.
// R18: Idle flag is set once per change from active to idle.
// R19: Five receiver flags; full, overrun and idle may interrupt.
// R20: Prescaler divides the clock by 1, 3, 4, 13 or 39.
// R21: Software keeps low prescaler bits zero when the top bit is set.
// R22: Status read while set, then data access, clears a flag.
module sbf_top (
	// Clock and reset.
	input wire ref_clk,
	input wire rst_b,
	// Register port.
	input wire [`SBF_ADDR_W-1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata_q,
	// Serial pins.
	input wire rxd_pin,
	output reg txd_out_q,
	output reg txd_oe_q,
	// Interrupt request.
	output reg irq_q
);
	localparam RX_IDLE = 1'b0;
	localparam RX_BUSY = 1'b1;

	reg rst_s1_q;
	reg rst_n_q;
	reg [2:0] rate_divider_select;
	reg [2:0] prescaler_select;
	reg [7:0] ctrl_q;
	reg tx_holding_empty;
	reg tx_complete_flag;
	reg rx_full_flag;
	reg idle_flag_q;
	reg overrun_flag_q;
	reg noise_flag;
	reg framing_error_flag;
	reg [7:0] arm_q;
	reg [7:0] tx_holding_reg;
	reg tx_hold_full_q;
	reg [8:0] tx_sh_q;
	reg [3:0] tx_cnt_q;
	reg tx_busy_q;
	reg [7:0] rx_holding_reg;
	reg rx_state_q;
	reg [3:0] rx_phase_q;
	reg [3:0] rx_bit_q;
	reg [7:0] rx_sh_q;
	reg [1:0] rx_smp_q;
	reg rx_noise_q;
	reg [7:0] idle_cnt_q;
	reg line_active_q;
	wire receiver_sample_clock;
	wire bit_tick;
	wire rx_line;
	wire xmit_on;
	wire recv_on;
	wire wr_ctrl;
	wire rd_stat;
	wire wr_data;
	wire rd_data;
	wire xmit_rise;
	wire xmit_fall;
	wire tx_load;
	wire tx_done;
	wire rx_mid;
	wire rx_maj;
	wire rx_char;
	wire idle_hit;
	wire [7:0] stat_word;

	// Reset is released through two flip-flops.
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	sbf_baud_div u_baud (
		.clk(ref_clk),
		.rst_n(rst_n_q),
		.prescaler_select(prescaler_select),
		.rate_divider_select(rate_divider_select),
		.sample_tick_q(receiver_sample_clock),
		.bit_tick_q(bit_tick)
	);

	sbf_sync3 #(
		.RESET_VAL(1'b1)
	) u_rx_sync (
		.clk(ref_clk),
		.rst_n(rst_n_q),
		.pin_in(rxd_pin),
		.level_q(rx_line)
	);

	// Register access decode.
	assign xmit_on = ctrl_q[`SBF_CTRL_XMIT_ON];
	assign recv_on = ctrl_q[`SBF_CTRL_RECV_ON];
	assign wr_ctrl = reg_wr && (reg_addr == `SBF_OFS_CTRL);
	assign rd_stat = reg_rd && (reg_addr == `SBF_OFS_STAT);
	assign wr_data = reg_wr && (reg_addr == `SBF_OFS_DATA);
	assign rd_data = reg_rd && (reg_addr == `SBF_OFS_DATA);
	assign xmit_rise = wr_ctrl && reg_wdata[`SBF_CTRL_XMIT_ON] && !xmit_on;
	assign xmit_fall = wr_ctrl && !reg_wdata[`SBF_CTRL_XMIT_ON] && xmit_on;
	assign stat_word = {tx_holding_empty, tx_complete_flag, rx_full_flag, idle_flag_q,
		overrun_flag_q, noise_flag, framing_error_flag, 1'b0};

	// Rate fields have no reset so a chosen rate survives it.
	always @(posedge ref_clk) begin
		if (reg_wr && (reg_addr == `SBF_OFS_BAUD)) begin
			rate_divider_select <= reg_wdata[`SBF_BAUD_RATE_LSB+2:`SBF_BAUD_RATE_LSB]; // see R04
			prescaler_select <= reg_wdata[`SBF_BAUD_PRE_LSB+2:`SBF_BAUD_PRE_LSB]; // see R21
		end
	end

	// Control register and registered read data, one cycle after the strobe.
	always @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ctrl_q <= `SBF_CTRL_RESET;
			reg_rdata_q <= 8'h00;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= {2'b00, reg_wdata[5:0]};
			end
			reg_rdata_q <= 8'h00;
			if (reg_rd) begin
				case (reg_addr)
					`SBF_OFS_BAUD: reg_rdata_q <= {1'b0, prescaler_select, 1'b0,
						rate_divider_select};
					`SBF_OFS_CTRL: reg_rdata_q <= ctrl_q;
					`SBF_OFS_STAT: reg_rdata_q <= stat_word;
					default: reg_rdata_q <= rx_holding_reg;
				endcase
			end
		end
	end

	// Transmit timing: a character loads at a bit tick and leaves LSB first.
	assign tx_load = bit_tick && !tx_busy_q && tx_hold_full_q && xmit_on;
	assign tx_done = bit_tick && tx_busy_q && (tx_cnt_q == 4'h0);

	// Transmit holding register and shifter.
	always @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			tx_holding_reg <= 8'h00;
			tx_hold_full_q <= 1'b0;
			tx_sh_q <= 9'h1FF;
			tx_cnt_q <= 4'h0;
			tx_busy_q <= 1'b0; // see R10
			txd_out_q <= 1'b1;
			txd_oe_q <= 1'b0;
		end else begin
			if (wr_data) begin
				tx_holding_reg <= reg_wdata;
				tx_hold_full_q <= 1'b1;
			end else if (xmit_fall || tx_load) begin
				tx_hold_full_q <= 1'b0; // see R12
			end
			if (tx_load) begin
				tx_sh_q <= {1'b1, tx_holding_reg};
				tx_cnt_q <= 4'h9;
				tx_busy_q <= 1'b1;
				txd_out_q <= 1'b0;
			end else if (tx_done) begin
				tx_busy_q <= 1'b0; // see R09
			end else if (bit_tick && tx_busy_q) begin
				txd_out_q <= tx_sh_q[0];
				tx_sh_q <= {1'b1, tx_sh_q[8:1]};
				tx_cnt_q <= tx_cnt_q - 4'h1;
			end
			if (xmit_rise) begin
				txd_oe_q <= 1'b1;
			end else if (bit_tick && !xmit_on && (!tx_busy_q || tx_done)) begin
				txd_oe_q <= 1'b0; // see R11
				txd_out_q <= 1'b1;
			end
		end
	end

	// Receiver sampling: majority of samples 7, 8 and 9 of each bit.
	assign rx_mid = receiver_sample_clock && (rx_state_q == RX_BUSY) && (rx_phase_q == 4'h9);
	assign rx_maj = (rx_smp_q[0] & rx_smp_q[1]) | (rx_smp_q[0] & rx_line) |
		(rx_smp_q[1] & rx_line);
	assign rx_char = rx_mid && (rx_bit_q == 4'h9);

	// Receive state machine.
	always @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rx_state_q <= RX_IDLE;
			rx_phase_q <= 4'h0;
			rx_bit_q <= 4'h0;
			rx_sh_q <= 8'h00;
			rx_smp_q <= 2'b11;
			rx_noise_q <= 1'b0;
		end else if (receiver_sample_clock) begin
			case (rx_state_q)
				RX_IDLE: begin
					rx_phase_q <= 4'h1;
					rx_bit_q <= 4'h0;
					rx_noise_q <= 1'b0;
					if (recv_on && !rx_line) begin
						rx_state_q <= RX_BUSY;
					end
				end
				RX_BUSY: begin
					rx_phase_q <= rx_phase_q + 4'h1;
					if (rx_phase_q == 4'h7) begin
						rx_smp_q[0] <= rx_line;
					end
					if (rx_phase_q == 4'h8) begin
						rx_smp_q[1] <= rx_line;
					end
					if (rx_phase_q == 4'hF) begin
						rx_bit_q <= rx_bit_q + 4'h1;
					end
					if (rx_phase_q == 4'h9) begin
						if (!(rx_smp_q[0] == rx_smp_q[1] && rx_smp_q[1] == rx_line)) begin
							rx_noise_q <= 1'b1;
						end
						if ((rx_bit_q == 4'h0 && rx_maj) || rx_bit_q == 4'h9) begin
							rx_state_q <= RX_IDLE;
						end else if (rx_bit_q != 4'h0) begin
							rx_sh_q <= {rx_maj, rx_sh_q[7:1]};
						end
					end
				end
				default: rx_state_q <= RX_IDLE;
			endcase
		end
	end

	// Idle detection counts sample ticks of a steady high line.
	assign idle_hit = receiver_sample_clock && line_active_q &&
		(idle_cnt_q == `SBF_IDLE_TICKS - 1);

	always @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			idle_cnt_q <= 8'h00;
			line_active_q <= 1'b0;
		end else if (receiver_sample_clock) begin
			if (!rx_line || !recv_on) begin
				idle_cnt_q <= 8'h00;
				line_active_q <= recv_on; // see R18
			end else if (idle_hit) begin
				idle_cnt_q <= 8'h00;
				line_active_q <= 1'b0; // see R17
			end else if (line_active_q) begin
				idle_cnt_q <= idle_cnt_q + 8'h01;
			end
		end
	end

	// Status flags: set wins over the software clear sequence.
	always @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			tx_holding_empty <= 1'b0;
			tx_complete_flag <= 1'b0;
			rx_full_flag <= 1'b0;
			idle_flag_q <= 1'b0;
			overrun_flag_q <= 1'b0;
			noise_flag <= 1'b0;
			framing_error_flag <= 1'b0;
			rx_holding_reg <= 8'h00;
			arm_q <= 8'h00;
		end else begin
			if (rd_stat) begin
				arm_q <= stat_word; // see R22
			end else if (wr_data) begin
				arm_q[7:6] <= 2'b00;
			end else if (rd_data) begin
				arm_q[5:0] <= 6'h00;
			end
			if (xmit_rise || tx_load || (tx_done && !xmit_on)) begin
				tx_holding_empty <= 1'b1; // see R06 R13
			end else if (wr_data && arm_q[`SBF_ST_TXE]) begin
				tx_holding_empty <= 1'b0; // see R05
			end
			if (xmit_rise || (tx_done && (!tx_hold_full_q || !xmit_on))) begin
				tx_complete_flag <= 1'b1; // see R06 R13
			end else if (wr_data && arm_q[`SBF_ST_TXC]) begin
				tx_complete_flag <= 1'b0;
			end
			if (rx_char && !rx_full_flag) begin
				rx_holding_reg <= rx_sh_q; // see R14
				rx_full_flag <= 1'b1;
				noise_flag <= rx_noise_q; // see R16
				framing_error_flag <= !rx_maj;
			end else if (rd_data && arm_q[`SBF_ST_RXF]) begin
				rx_full_flag <= 1'b0;
				noise_flag <= noise_flag & !arm_q[`SBF_ST_NOISE];
				framing_error_flag <= framing_error_flag & !arm_q[`SBF_ST_FRAME];
			end
			if (rx_char && rx_full_flag) begin
				overrun_flag_q <= 1'b1; // see R15
			end else if (rd_data && arm_q[`SBF_ST_OVR]) begin
				overrun_flag_q <= 1'b0;
			end
			if (idle_hit) begin
				idle_flag_q <= 1'b1; // see R18
			end else if (rd_data && arm_q[`SBF_ST_IDLE]) begin
				idle_flag_q <= 1'b0;
			end
		end
	end

	// Interrupt request from enabled flags; noise and framing never take part.
	always @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= (tx_holding_empty & ctrl_q[`SBF_CTRL_TXE_IE]) | // see R07
				(tx_complete_flag & ctrl_q[`SBF_CTRL_TXC_IE]) | // see R08
				((rx_full_flag | overrun_flag_q) & ctrl_q[`SBF_CTRL_RXF_IE]) | // see R19
				(idle_flag_q & ctrl_q[`SBF_CTRL_IDLE_IE]);
		end
	end
endmodule

/* File: sbf_top_asserts.sv */
// Port-level checker for the serial block.
`timescale 1ns/100ps
`include "sbf_regs.vh"
module sbf_top_asserts (
	// Clock and reset.
	input wire ref_clk,
	input wire rst_b,
	// Register port.
	input wire [`SBF_ADDR_W-1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata_q,
	// Serial pins and interrupt.
	input wire rxd_pin,
	input wire txd_out_q,
	input wire txd_oe_q,
	input wire irq_q
);
	reg [7:0] ctrl_q;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// Shadow of the control register, so masking can be judged.
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_q <= 8'h00;
		end else if (reg_wr && reg_addr == `SBF_OFS_CTRL) begin
			ctrl_q <= reg_wdata;
		end
	end
	// No bit on the wire is shorter than eight cycles, half the fastest bit period.
	sequence low_hold;
		(!txd_out_q) [*8];
	endsequence
	sequence high_hold;
		txd_out_q [*8];
	endsequence
	rdata_zero_a: assert property (!$past(reg_rd) |-> reg_rdata_q == 8'h00)
		else $error("read data outside its slot");
	stat_pad_a: assert property ($past(reg_rd) && $past(reg_addr) == `SBF_OFS_STAT
		|-> reg_rdata_q[0] == 1'b0) else $error("status pad bit set");
	idle_high_a: assert property (!txd_oe_q |-> txd_out_q)
		else $error("released pin not high");
	drive_zero_a: assert property (!txd_out_q |-> txd_oe_q)
		else $error("low bit with pin released");
	low_bit_a: assert property ($fell(txd_out_q) |-> low_hold)
		else $error("low bit too short");
	high_bit_a: assert property ($rose(txd_out_q) |-> high_hold)
		else $error("high bit too short");
	oe_drop_a: assert property ($fell(txd_oe_q) |-> $past(txd_out_q, 8))
		else $error("pin released inside a character");
	irq_mask_a: assert property ((ctrl_q[5:2] == 4'h0) [*2] |=> !irq_q)
		else $error("interrupt with all enables off");
endmodule
bind sbf_top sbf_top_asserts chk_u (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
	.rxd_pin(rxd_pin), .txd_out_q(txd_out_q), .txd_oe_q(txd_oe_q), .irq_q(irq_q));

/* File: sbf_far_end.sv */
// Remote serial transceiver facing the block's pins.
`timescale 1ns/100ps
module sbf_far_end (
	// Clock.
	input wire clk,
	// Serial lines.
	input wire line_in,
	output reg line_out
);
	integer bit_cyc;
	integer n_rx;
	integer i;
	reg [7:0] sh;
	reg [7:0] rx_log [0:63];
	// Idle line is high; the bit period follows the bench's rate setting.
	initial begin
		bit_cyc = 16;
		n_rx = 0;
		line_out = 1'b1;
	end
	// Receiver samples each bit in its middle and logs the byte.
	always begin
		@(negedge line_in);
		repeat (bit_cyc / 2) @(posedge clk);
		if (!line_in) begin
			for (i = 0; i < 8; i = i + 1) begin
				repeat (bit_cyc) @(posedge clk);
				sh[i] = line_in;
			end
			repeat (bit_cyc) @(posedge clk);
			rx_log[n_rx] = sh;
			n_rx = n_rx + 1;
		end
	end
	// Sends one frame LSB first; a low stop bit breaks framing on purpose.
	task send(input [7:0] d, input stop);
		integer k;
		reg [9:0] frm;
		begin
			frm = {stop, d, 1'b0};
			for (k = 0; k < 10; k = k + 1) begin
				@(posedge clk);
				line_out <= frm[k];
				repeat (bit_cyc - 1) @(posedge clk);
			end
			@(posedge clk);
			line_out <= 1'b1;
		end
	endtask
endmodule

/* File: async_serial_baud_and_flags_bench.sv */
// Self-checking bench for the serial block.
`timescale 1ns/100ps
`include "sbf_regs.vh"
module async_serial_baud_and_flags_bench;
	// Rate codes tried in turn; the top prescaler code keeps its low bits zero.
	localparam [47:0] BAUDS = 48'h0007_4030_2211;
	reg ref_clk = 1'b0;
	reg rst_b = 1'b0;
	reg [`SBF_ADDR_W-1:0] reg_addr = 2'h0;
	reg [7:0] reg_wdata = 8'h00;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	wire [7:0] reg_rdata_q;
	wire rxd_pin;
	wire txd_out_q;
	wire txd_oe_q;
	wire irq_q;
	wire tx_line = txd_oe_q ? txd_out_q : 1'b1; // Pull-up on the released pin.
	integer n_fail = 0;
	integer n_compared = 0;
	integer cyc = 0;
	integer i;
	integer t;
	integer n0;
	reg [7:0] v;
	reg [7:0] b0;
	reg [7:0] b1;
	reg [7:0] sent [0:3];
	always #2 ref_clk = ~ref_clk;
	sbf_top dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.rxd_pin(rxd_pin), .txd_out_q(txd_out_q), .txd_oe_q(txd_oe_q), .irq_q(irq_q));
	sbf_far_end far_u (.clk(ref_clk), .line_in(tx_line), .line_out(rxd_pin));
	// Cuts a hang short.
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			n_fail = n_fail + 1;
			test_done;
		end
	end
	function [15:0] exp_bit(input [7:0] bd);
		reg [15:0] p;
		begin
			case (bd[6:4])
				3'h1: p = 16'h0003;
				3'h2: p = 16'h0004;
				3'h3: p = 16'h000D;
				3'h4: p = 16'h0027;
				default: p = 16'h0001;
			endcase
			exp_bit = (p << bd[2:0]) * 16'h0010;
		end
	endfunction
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		begin
			n_compared = n_compared + 1;
			if (seen !== exp) begin
				n_fail = n_fail + 1;
				$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task wr(input [1:0] a, input [7:0] d);
		begin
			@(posedge ref_clk);
			reg_wr <= 1'b1;
			reg_addr <= a;
			reg_wdata <= d;
			@(posedge ref_clk);
			reg_wr <= 1'b0;
		end
	endtask
	// Reads a register and compares the bits under the mask.
	task rd(input [1:0] a, input [7:0] e, input [7:0] m);
		begin
			@(posedge ref_clk);
			reg_rd <= 1'b1;
			reg_addr <= a;
			@(posedge ref_clk);
			reg_rd <= 1'b0;
			#1 v = reg_rdata_q;
			if (m != 8'h00) chk({8'h00, v & m}, {8'h00, e & m});
		end
	endtask
	task poll(input integer b);
		begin
			t = 0;
			v = 8'h00;
			while (v[b] !== 1'b1 && t < 20000) begin
				rd(`SBF_OFS_STAT, 8'h00, 8'h00);
				t = t + 1;
			end
			chk({15'h0000, v[b]}, 16'h0001);
		end
	endtask
	task oe_off;
		begin
			t = 0;
			while (txd_oe_q !== 1'b0 && t < 600) begin
				@(negedge ref_clk);
				t = t + 1;
			end
			chk({15'h0000, txd_oe_q}, 16'h0000);
		end
	endtask
	task irq_is(input e);
		begin
			repeat (3) @(negedge ref_clk);
			chk({15'h0000, irq_q}, {15'h0000, e});
		end
	endtask
	// Sends 0xFF and times the start bit.
	task bit_time(input [7:0] bd);
		begin
			wr(`SBF_OFS_BAUD, bd);
			far_u.bit_cyc = exp_bit(bd);
			poll(`SBF_ST_TXE);
			wr(`SBF_OFS_DATA, 8'hFF);
			t = 0;
			while (tx_line && t < 5000) begin
				@(negedge ref_clk);
				t = t + 1;
			end
			n0 = 0;
			while (!tx_line && n0 < 5000) begin
				@(negedge ref_clk);
				n0 = n0 + 1;
			end
			chk(n0[15:0], exp_bit(bd));
			poll(`SBF_ST_TXC);
			chk({8'h00, far_u.rx_log[far_u.n_rx - 1]}, 16'h00FF);
		end
	endtask
	task test_done;
		begin
			$display("compared %0d failed %0d", n_compared, n_fail);
			if (n_fail == 0 && n_compared > 0) begin
				$display("ALL TESTS PASSED");
			end else begin
				$display("TESTS FAILED");
			end
			$finish;
		end
	endtask
	// Main sequence.
	initial begin
		n0 = $urandom(1293);
		repeat (4) @(posedge ref_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge ref_clk);
		wr(`SBF_OFS_BAUD, 8'h35);
		@(posedge ref_clk);
		rst_b <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rd(`SBF_OFS_BAUD, 8'h35, 8'h77);
		rd(`SBF_OFS_CTRL, 8'h00, 8'hFF);
		wr(`SBF_OFS_BAUD, 8'h00);
		wr(`SBF_OFS_CTRL, 8'h01);
		rd(`SBF_OFS_STAT, 8'hC0, 8'hC0);
		wr(`SBF_OFS_CTRL, 8'h00);
		oe_off;
		chk({15'h0000, t < 17}, 16'h0001);
		wr(`SBF_OFS_CTRL, 8'h01);
		for (i = 0; i < 6; i = i + 1) bit_time(BAUDS[i * 8 +: 8]);
		n0 = far_u.n_rx;
		for (i = 0; i < 4; i = i + 1) begin
			sent[i] = 8'($urandom);
			poll(`SBF_ST_TXE);
			wr(`SBF_OFS_DATA, sent[i]);
		end
		poll(`SBF_ST_TXC);
		for (i = 0; i < 4; i = i + 1) chk({8'h00, far_u.rx_log[n0 + i]}, {8'h00, sent[i]});
		wr(`SBF_OFS_CTRL, 8'h05);
		irq_is(1'b1);
		wr(`SBF_OFS_CTRL, 8'h09);
		irq_is(1'b1);
		wr(`SBF_OFS_CTRL, 8'h01);
		irq_is(1'b0);
		n0 = far_u.n_rx;
		b0 = 8'($urandom);
		b1 = 8'($urandom);
		poll(`SBF_ST_TXE);
		wr(`SBF_OFS_DATA, b0);
		poll(`SBF_ST_TXE);
		wr(`SBF_OFS_DATA, b1);
		wr(`SBF_OFS_CTRL, 8'h00);
		// The character on the wire is still going, so neither flag may be set yet.
		rd(`SBF_OFS_STAT, 8'h00, 8'hC0);
		oe_off;
		repeat (200) @(posedge ref_clk);
		chk({15'h0000, far_u.n_rx == n0 + 1}, 16'h0001);
		chk({8'h00, far_u.rx_log[n0]}, {8'h00, b0});
		rd(`SBF_OFS_STAT, 8'hC0, 8'hC0);
		wr(`SBF_OFS_CTRL, 8'h12);
		far_u.send(b0, 1'b1);
		poll(`SBF_ST_RXF);
		irq_is(1'b1);
		rd(`SBF_OFS_DATA, b0, 8'hFF);
		poll(`SBF_ST_IDLE);
		wr(`SBF_OFS_CTRL, 8'h22);
		irq_is(1'b1);
		rd(`SBF_OFS_DATA, 8'h00, 8'h00);
		irq_is(1'b0);
		wr(`SBF_OFS_CTRL, 8'h12);
		repeat (400) @(posedge ref_clk);
		rd(`SBF_OFS_STAT, 8'h00, 8'h38);
		far_u.send(b0, 1'b1);
		far_u.send(b1, 1'b1);
		poll(`SBF_ST_OVR);
		rd(`SBF_OFS_DATA, b0, 8'hFF);
		wr(`SBF_OFS_CTRL, 8'h22);
		far_u.send(b1, 1'b0);
		poll(`SBF_ST_FRAME);
		irq_is(1'b0);
		rd(`SBF_OFS_DATA, b1, 8'hFF);
		test_done;
	end
endmodule
